//--- core/qlink_regs.sv
`timescale 1ns/100ps
// Function
// - region 0 base is two 16-bit writable halves, low and high.
// - region 1 base is likewise two 16-bit writable halves.
// - any 32-bit base accepted; link address is a full 32-bit sum.
// - only full 16-bit accesses; no byte accesses exist or are issued.
// - region 0 count holds 14 writable bits; bits 15:14 read zero.
// - index below region 0 count maps into region 0.
// - index at or above region 0 count maps into region 1.
// - link address is chosen base plus index shifted left by two.
// - six pending registers; register k bit i is queue 16k+i.
// - pending registers are read-only, reset to zero, writes ignored.
module qlink_regs (
   input  wire logic                          i_clk_sys,
   input  wire logic                          i_resetn,
   input  wire logic [qlink_pkg::ADDR_W-1:0]  i_addr,
   input  wire logic [qlink_pkg::DATA_W-1:0]  i_wdata,
   input  wire logic                          i_wr,
   input  wire logic                          i_rd,
   output logic      [qlink_pkg::DATA_W-1:0]  o_rdata,
   input  wire logic [qlink_pkg::NUM_Q-1:0]   i_queue_nonempty,
   input  wire logic                          i_lookup_req,
   input  wire logic [qlink_pkg::IDX_W-1:0]   i_lookup_index,
   output logic                               o_lookup_valid,
   output logic                               o_lookup_region1,
   output logic      [qlink_pkg::LADDR_W-1:0] o_lookup_addr,
   output logic                               o_irq
);
   import qlink_pkg::*;

   logic [15:0]      r0_base_lo_r;
   logic [15:0]      r0_base_hi_r;
   logic [13:0]      r0_count_r;
   logic [15:0]      r1_base_lo_r;
   logic [15:0]      r1_base_hi_r;
   logic [NUM_Q-1:0] pend_r;
   logic [1:0]       irq_status_r;
   logic [1:0]       irq_mask_r;
   logic [1:0]       irq_set;
   logic [15:0]      rdata_nxt;
   logic [2:0]       pend_sel;
   logic             lookup_req_r;
   logic [13:0]      lookup_index_r;

   link_addr_if la ();

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         r0_base_lo_r <= RST_REG16;
         r0_base_hi_r <= RST_REG16;
      end else if (i_wr) begin
         if (i_addr == OFS_R0_BASE_LO) begin
            r0_base_lo_r <= i_wdata;
         end
         if (i_addr == OFS_R0_BASE_HI) begin
            r0_base_hi_r <= i_wdata;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         r1_base_lo_r <= RST_REG16;
         r1_base_hi_r <= RST_REG16;
      end else if (i_wr) begin
         if (i_addr == OFS_R1_BASE_LO) begin
            r1_base_lo_r <= i_wdata;
         end
         if (i_addr == OFS_R1_BASE_HI) begin
            r1_base_hi_r <= i_wdata;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         r0_count_r <= RST_COUNT;
      end else if (i_wr && i_addr == OFS_R0_COUNT) begin
         r0_count_r <= i_wdata[13:0];
      end
   end

   // pending follows queue occupancy, never software
   // queue flags come from same-clock queue logic, so no synchroniser
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         pend_r <= '0;
      end else begin
         pend_r <= i_queue_nonempty;
      end
   end

   // lookup requests registered so the calculator sees stable inputs
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         lookup_req_r   <= 1'b0;
         lookup_index_r <= RST_COUNT;
      end else begin
         lookup_req_r   <= i_lookup_req;
         lookup_index_r <= i_lookup_index;
      end
   end

   // base used as written, low bits trusted zero
   assign la.base0  = {r0_base_hi_r, r0_base_lo_r};
   assign la.base1  = {r1_base_hi_r, r1_base_lo_r};
   assign la.count0 = r0_count_r;
   assign la.req    = lookup_req_r;
   assign la.index  = lookup_index_r;

   link_addr_calc u_calc (
      .i_clk_sys (i_clk_sys),
      .i_resetn  (i_resetn),
      .la        (la)
   );

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_lookup_valid   <= 1'b0;
         o_lookup_region1 <= 1'b0;
         o_lookup_addr    <= RST_LADDR;
      end else begin
         o_lookup_valid   <= la.valid;
         o_lookup_region1 <= la.region1;
         o_lookup_addr    <= la.addr;
      end
   end

   // events: lookup finished, any queue went from empty to pending
   always_comb begin
      irq_set                  = 2'b00;
      irq_set[IRQ_LOOKUP_DONE] = la.valid;
      irq_set[IRQ_PEND_RISE]   = |(i_queue_nonempty & ~pend_r);
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         irq_status_r <= RST_IRQ;
      end else if (i_wr && i_addr == OFS_IRQ_STATUS) begin
         irq_status_r <= (irq_status_r & ~i_wdata[1:0]) | irq_set;
      end else begin
         irq_status_r <= irq_status_r | irq_set;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         irq_mask_r <= RST_IRQ;
      end else if (i_wr && i_addr == OFS_IRQ_MASK) begin
         irq_mask_r <= i_wdata[1:0];
      end
   end

   // level output, one cycle behind status
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_status_r & irq_mask_r);
      end
   end

   assign pend_sel = 3'(i_addr - OFS_PEND_FIRST);

   // every access is a whole 16-bit word
   always_comb begin
      rdata_nxt = UNMAPPED_READ;
      if (i_addr >= OFS_PEND_FIRST && i_addr <= OFS_PEND_LAST) begin
         // register k bit i is queue 16k+i
         rdata_nxt = pend_r[pend_sel*DATA_W +: DATA_W];
      end else begin
         unique case (i_addr)
            OFS_R0_BASE_LO: rdata_nxt = r0_base_lo_r;
            OFS_R0_BASE_HI: rdata_nxt = r0_base_hi_r;
            OFS_R0_COUNT:   rdata_nxt = {2'b00, r0_count_r};
            OFS_R1_BASE_LO: rdata_nxt = r1_base_lo_r;
            OFS_R1_BASE_HI: rdata_nxt = r1_base_hi_r;
            OFS_IRQ_STATUS: rdata_nxt = {14'h0000, irq_status_r};
            OFS_IRQ_MASK:   rdata_nxt = {14'h0000, irq_mask_r};
            default:        rdata_nxt = UNMAPPED_READ;
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_rdata <= UNMAPPED_READ;
      end else if (i_rd) begin
         o_rdata <= rdata_nxt;
      end else begin
         o_rdata <= UNMAPPED_READ;
      end
   end
endmodule : qlink_regs

//--- core/qlink_pkg.sv
package qlink_pkg;
   localparam int unsigned ADDR_W   = 5;
   localparam int unsigned DATA_W   = 16;
   localparam int unsigned NUM_Q    = 96;
   localparam int unsigned NUM_PEND = 6;
   localparam int unsigned IDX_W    = 14;
   localparam int unsigned LADDR_W  = 32;
   localparam int unsigned IDX_SHIFT = 2;

   // register offsets (word index on the plain port)
   localparam logic [4:0] OFS_R0_BASE_LO  = 5'h00;
   localparam logic [4:0] OFS_R0_BASE_HI  = 5'h01;
   localparam logic [4:0] OFS_R0_COUNT    = 5'h02;
   localparam logic [4:0] OFS_R1_BASE_LO  = 5'h03;
   localparam logic [4:0] OFS_R1_BASE_HI  = 5'h04;
   localparam logic [4:0] OFS_PEND_FIRST  = 5'h08;
   localparam logic [4:0] OFS_PEND_LAST   = 5'h0d;
   localparam logic [4:0] OFS_IRQ_STATUS  = 5'h10;
   localparam logic [4:0] OFS_IRQ_MASK    = 5'h11;
   localparam logic [4:0] OFS_RAW_PEND_LO = 5'h12;

   localparam logic [15:0] RST_REG16      = 16'h0000;
   localparam logic [13:0] RST_COUNT      = 14'h0000;
   localparam logic [1:0]  RST_IRQ        = 2'h0;
   localparam logic [31:0] RST_LADDR      = 32'h0000_0000;
   localparam logic [15:0] UNMAPPED_READ  = 16'h0000;

   // interrupt status bit positions
   localparam int unsigned IRQ_LOOKUP_DONE = 0;
   localparam int unsigned IRQ_PEND_RISE   = 1;
endpackage : qlink_pkg

//--- core/link_addr_if.sv
`timescale 1ns/100ps
interface link_addr_if;
   import qlink_pkg::*;
   logic [31:0] base0;
   logic [31:0] base1;
   logic [13:0] count0;
   logic        req;
   logic [13:0] index;
   logic        valid;
   logic        region1;
   logic [31:0] addr;
   modport calc (input base0, base1, count0, req, index, output valid, region1, addr);
   modport user (output base0, base1, count0, req, index, input valid, region1, addr);
endinterface : link_addr_if

//--- core/link_addr_calc.sv
`timescale 1ns/100ps
module link_addr_calc (
   input  wire logic    i_clk_sys,
   input  wire logic    i_resetn,
   link_addr_if.calc    la
);
   import qlink_pkg::*;

   logic        region1_sel;
   logic [31:0] offset;
   logic [31:0] base_sel;

   // index at or above count goes to region 1
   assign region1_sel = (la.index >= la.count0);
   assign offset      = {{(LADDR_W-IDX_W-IDX_SHIFT){1'b0}}, la.index, {IDX_SHIFT{1'b0}}};
   // below count stays in region 0
   assign base_sel    = region1_sel ? la.base1 : la.base0;

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         la.valid   <= 1'b0;
         la.region1 <= 1'b0;
         la.addr    <= RST_LADDR;
      end else begin
         la.valid <= la.req;
         if (la.req) begin
            la.region1 <= region1_sel;
            // full 32-bit sum, wraps modulo 2^32
            la.addr    <= base_sel + offset;
         end
      end
   end
endmodule : link_addr_calc

//--- dv/qlink_regs_sva.sv
`timescale 1ns/100ps
module qlink_regs_sva import qlink_pkg::*; (
   input wire logic                          i_clk_sys,
   input wire logic                          i_resetn,
   input wire logic [qlink_pkg::ADDR_W-1:0]  i_addr,
   input wire logic [qlink_pkg::DATA_W-1:0]  i_wdata,
   input wire logic                          i_wr,
   input wire logic                          i_rd,
   input wire logic [qlink_pkg::DATA_W-1:0]  o_rdata,
   input wire logic [qlink_pkg::NUM_Q-1:0]   i_queue_nonempty,
   input wire logic                          i_lookup_req,
   input wire logic [qlink_pkg::IDX_W-1:0]   i_lookup_index,
   input wire logic                          o_lookup_valid,
   input wire logic                          o_lookup_region1,
   input wire logic [qlink_pkg::LADDR_W-1:0] o_lookup_addr,
   input wire logic                          o_irq
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data not idle");
   a_lookup_answer_time: assert property (i_lookup_req |-> ##3 o_lookup_valid)
      else $error("lookup result late");
   a_lookup_valid_cause: assert property (o_lookup_valid |-> $past(i_lookup_req, 3))
      else $error("lookup result without request");
   a_addr_held: assert property (!o_lookup_valid |-> $stable(o_lookup_addr))
      else $error("link address moved");
   a_region_held: assert property (!o_lookup_valid |-> $stable(o_lookup_region1))
      else $error("region flag moved");
   a_count_top_zero: assert property (i_rd && i_addr == OFS_R0_COUNT |=> o_rdata[15:14] == 2'h0)
      else $error("count top bits set");
   a_pend_first_map: assert property (i_rd && i_addr == OFS_PEND_FIRST |=>
      o_rdata == $past(i_queue_nonempty[15:0], 2)) else $error("first pending wrong");
   a_pend_last_map: assert property (i_rd && i_addr == OFS_PEND_LAST |=>
      o_rdata == $past(i_queue_nonempty[95:80], 2)) else $error("last pending wrong");
   cover property (o_lookup_valid && o_lookup_region1);
   cover property ($rose(o_irq));
   cover property (i_rd && i_addr == OFS_PEND_LAST);
endmodule : qlink_regs_sva
bind qlink_regs qlink_regs_sva u_qlink_regs_sva (.*);

//--- dv/link_ram_model.sv
`timescale 1ns/100ps
module link_ram_model (
   input  wire logic        i_clk_sys,
   input  wire logic        i_valid,
   input  wire logic [31:0] i_addr,
   output logic      [31:0] o_last_addr,
   output int               o_hits
);
   initial begin
      o_hits      = 0;
      o_last_addr = '0;
   end
   always @(posedge i_clk_sys) begin
      if (i_valid) begin
         o_last_addr <= i_addr;
         o_hits      <= o_hits + 1;
      end
   end
endmodule : link_ram_model

//--- dv/qlink_regs_tb.sv
`timescale 1ns/100ps
module qlink_regs_tb;
   import qlink_pkg::*;
   logic        clk, resetn, wr_s, rd_s, lreq, lval, lr1, irq;
   logic [4:0]  addr;
   logic [15:0] wdata, rdata;
   logic [95:0] qne;
   logic [13:0] lidx;
   logic [31:0] laddr, last_addr;
   int          hits, num_errors, checks_done;
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   qlink_regs u_qlink_regs (.i_clk_sys(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_queue_nonempty(qne), .i_lookup_req(lreq),
      .i_lookup_index(lidx), .o_lookup_valid(lval), .o_lookup_region1(lr1), .o_lookup_addr(laddr),
      .o_irq(irq));
   link_ram_model u_link_ram_model (.i_clk_sys(clk), .i_valid(lval), .i_addr(laddr),
      .o_last_addr(last_addr), .o_hits(hits));
   task chk(string n, logic [31:0] got, logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s exp %h got %h", n, exp, got);
      end
   endtask : chk
   task reg_wr(logic [4:0] a, logic [15:0] d);
      @(posedge clk);
      {wr_s, addr, wdata} <= {1'b1, a, d};
      @(posedge clk);
      wr_s <= 0;
   endtask : reg_wr
   task reg_rd(logic [4:0] a, logic [15:0] e);
      @(posedge clk);
      {rd_s, addr} <= {1'b1, a};
      @(posedge clk);
      rd_s <= 0;
      #1 chk("rdata", rdata, e);
   endtask : reg_rd
   task lookup(logic [13:0] i, logic [31:0] e, logic r);
      @(posedge clk);
      {lreq, lidx} <= {1'b1, i};
      @(posedge clk);
      lreq <= 0;
      // result pulse stands between the second and third edge after the taking edge
      repeat (2) @(posedge clk);
      #1 chk("valid", lval, 1);
      chk("laddr", laddr, e);
      chk("region", lr1, r);
   endtask : lookup
   task end_sim;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   // whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_sim;
   end
   initial begin
      {wr_s, rd_s, lreq, addr, wdata, qne, lidx} = 0;
      {resetn, num_errors, checks_done} = 0;
      repeat (16) @(posedge clk);
      resetn <= 1;
      for (int a = 0; a < 18; a++) reg_rd(a[4:0], 16'h0000);
      reg_wr(OFS_R0_BASE_LO, 16'h0f00);
      reg_wr(OFS_R0_BASE_HI, 16'h8000);
      reg_wr(OFS_R1_BASE_LO, 16'hfff0);
      reg_wr(OFS_R1_BASE_HI, 16'hffff);
      reg_wr(OFS_R0_COUNT, 16'hffff);
      reg_rd(OFS_R0_COUNT, 16'h3fff);
      reg_rd(OFS_R0_BASE_HI, 16'h8000);
      reg_rd(OFS_R1_BASE_LO, 16'hfff0);
      reg_wr(OFS_R0_COUNT, 16'h0010);
      lookup(14'h000f, 32'h8000_0f3c, 0);
      lookup(14'h0010, 32'h0000_0030, 1);
      lookup(14'h3fff, 32'h0000_ffec, 1);
      reg_wr(OFS_IRQ_MASK, 16'h0002);
      reg_rd(OFS_IRQ_STATUS, 16'h0001);
      chk("irq", irq, 0);
      chk("hits", hits, 3);
      chk("last", last_addr, 32'h0000_ffec);
      @(posedge clk);
      qne <= 96'h8000_0000_0000_0000_0002_0000;
      repeat (3) @(posedge clk);
      #1 chk("irq", irq, 1);
      for (int k = 0; k < 6; k++) reg_rd(OFS_PEND_FIRST + k[4:0], qne[16*k +: 16]);
      reg_wr(5'h09, 16'h0000);
      reg_rd(5'h09, 16'h0002);
      reg_rd(OFS_IRQ_STATUS, 16'h0003);
      reg_wr(OFS_IRQ_STATUS, 16'h0002);
      reg_rd(OFS_IRQ_STATUS, 16'h0001);
      chk("irq", irq, 0);
      @(posedge clk);
      qne <= 0;
      reg_rd(OFS_PEND_LAST, 16'h0000);
      end_sim;
   end
endmodule : qlink_regs_tb
